// ### rtl/npic_defines.vh
// constants shared by the nested priority interrupt controller
`ifndef NPIC_DEFINES_VH
`define NPIC_DEFINES_VH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define NPIC_IDX_PRIO_A   6'h24
`define NPIC_IDX_PRIO_B   6'h25
`define NPIC_IDX_PRIO_C   6'h26
`define NPIC_IDX_PRIO_D   6'h27
`define NPIC_IDX_EDGE     6'h28
`define NPIC_IDX_STATUS   6'h29

// ----------------------------------------------------------------
// reset values and fixed bits
// ----------------------------------------------------------------
`define NPIC_PRIO_RST     8'hff
`define NPIC_EDGE_RST     8'h00
`define NPIC_PRIO_D_FIXED 8'hf0
`define NPIC_PRIO_D_WMASK 8'h0f

// ----------------------------------------------------------------
// level codes {high, low} and flag register bit positions
// ----------------------------------------------------------------
`define NPIC_LVL0         2'h2
`define NPIC_LVL1         2'h1
`define NPIC_LVL2         2'h0
`define NPIC_LVL3         2'h3
`define NPIC_FLAG_HIGH    5
`define NPIC_FLAG_LOW     3

// ----------------------------------------------------------------
// vectors in hardware order, 0 is highest
// ----------------------------------------------------------------
`define NPIC_VEC_TOP      16'hfffe
`define NPIC_VIDX_RESET   4'h0
`define NPIC_VIDX_TRAP    4'h1
`define NPIC_VIDX_FIRST   4'h2

// ----------------------------------------------------------------
// stack push order
// ----------------------------------------------------------------
`define NPIC_STK_PC       2'h0
`define NPIC_STK_X        2'h1
`define NPIC_STK_A        2'h2
`define NPIC_STK_FLAGS    2'h3

`endif

// ### rtl/npic_arbiter.v
// priority arbiter: picks the pending vector that may pre-empt the current level
`timescale 1ns/1ps
`default_nettype none
`include "npic_defines.vh"

module npic_arbiter #(
    parameter NV = 14
) (
    input  wire [NV-1:0]   req,      // gated requests per vector
    input  wire [2*NV-1:0] prio,     // two-bit level code per vector
    input  wire [1:0]      cur_code, // current level mask code
    output reg             found,    // a request may be taken
    output reg  [3:0]      idx,      // winning vector, maskable numbering
    output reg  [1:0]      code      // level code of the winner
);

    integer i;

    // ----------------------------------------------------------------
    // code to rank: level 0 lowest, level 3 highest
    // ----------------------------------------------------------------
    function [1:0] rank;
        input [1:0] c;
        begin
            case (c)
                `NPIC_LVL0: rank = 2'h0;
                `NPIC_LVL1: rank = 2'h1;
                `NPIC_LVL2: rank = 2'h2;
                default:    rank = 2'h3;
            endcase
        end
    endfunction

    // descending scan so the lowest index is the last to overwrite
    always @* begin
        found = 1'b0;
        idx   = 4'h0;
        code  = `NPIC_LVL3;
        for (i = NV - 1; i >= 0; i = i - 1) begin
            if (req[i] && (rank(prio[2*i +: 2]) > rank(cur_code))) begin
                found = 1'b1;
                idx   = i[3:0];
                code  = prio[2*i +: 2];
            end
        end
    end

endmodule // npic_arbiter

`default_nettype wire

// ### rtl/npic_top.v
// nested priority interrupt controller with avalon-mm register access
`timescale 1ns/1ps
`default_nettype none
`include "npic_defines.vh"

module npic_top #(
    parameter NV = 14
) (
    input  wire        SYS_CLK,          // core clock, 100 mhz
    input  wire        RST_N,            // synchronous reset, active low
    input  wire [7:0]  AVS_ADDRESS,      // byte address
    input  wire        AVS_READ,         // read request
    input  wire        AVS_WRITE,        // write request
    input  wire [31:0] AVS_WRITEDATA,    // write data
    input  wire [3:0]  AVS_BYTEENABLE,   // byte lanes
    output reg  [31:0] AVS_READDATA,     // read data
    output reg         AVS_WAITREQUEST,  // stall
    input  wire [NV-1:0] SRC_EVENT,      // peripheral event flags
    input  wire [NV-1:0] SRC_ENABLE,     // peripheral enable bits
    input  wire        CORE_INSTR_DONE,  // instruction boundary pulse
    input  wire        CORE_TRAP,        // trap instruction pulse
    input  wire        CORE_RETURN,      // return_from_interrupt pulse
    input  wire [7:0]  CORE_POP_FLAGS,   // flags popped by the return
    input  wire [7:0]  CORE_FLAGS,       // live cpu_flag_register
    input  wire        CORE_STK_ACK,     // core stored one stack item
    output reg         IRQ_PENDING,      // entry wanted at next boundary
    output reg         STK_PUSH,         // push request
    output reg  [1:0]  STK_SEL,          // which item to push
    output reg  [7:0]  PUSH_FLAGS,       // flags value to push
    output reg         VEC_LOAD,         // load pc from VEC_ADDR
    output reg  [15:0] VEC_ADDR,         // vector address
    output reg         LEVEL_MASK_HIGH,  // level_mask_high
    output reg         LEVEL_MASK_LOW,   // level_mask_low
    output reg  [7:0]  EXT_EDGE_CTRL     // ext_int_edge_control
);

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_WAIT = 4'h2;
    localparam [3:0] ST_PUSH = 4'h4;
    localparam [3:0] ST_VEC  = 4'h8;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    reg  [7:0]      prio_vectors_a;
    reg  [7:0]      prio_vectors_b;
    reg  [7:0]      prio_vectors_c;
    reg  [7:0]      prio_vectors_d;
    reg  [3:0]      state;
    reg  [3:0]      sel_vec;
    reg  [1:0]      sel_code;
    reg             trap_pend;
    reg  [7:0]      rd_byte;
    reg  [3:0]      next_state;
    reg  [3:0]      next_sel_vec;
    reg  [1:0]      next_sel_code;
    reg  [1:0]      next_mask;
    reg             next_irq;
    reg             next_push;
    reg  [1:0]      next_stk_sel;
    reg  [7:0]      next_push_flags;
    reg             next_vec_load;
    reg  [15:0]     next_vec_addr;
    reg             next_waitreq;
    reg  [31:0]     next_rdata;
    reg  [7:0]      next_prio_a;
    reg  [7:0]      next_prio_b;
    reg  [7:0]      next_prio_c;
    reg  [7:0]      next_prio_d;
    reg  [7:0]      next_edge;
    reg             entry_go;
    reg  [3:0]      entry_vec;
    reg  [1:0]      entry_code;

    wire [NV-1:0]   req;
    wire [2*NV-1:0] prio_all;
    wire [1:0]      cur_code;
    wire            arb_found;
    wire [3:0]      arb_idx;
    wire [1:0]      arb_code;
    wire [5:0]      reg_idx;
    wire            wr_go;
    wire            take_trap;
    wire [7:0]      status;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function [15:0] vec_addr;
        input [3:0] v;
        begin
            vec_addr = `NPIC_VEC_TOP - {11'h000, v, 1'b0};
        end
    endfunction

    // flags with the level mask merged into its two bit positions
    function [7:0] merge_flags;
        input [7:0] f;
        input [1:0] c;
        reg   [7:0] t;
        begin
            t = f;
            t[`NPIC_FLAG_HIGH] = c[1];
            t[`NPIC_FLAG_LOW]  = c[0];
            merge_flags = t;
        end
    endfunction

    // ----------------------------------------------------------------
    // request gating and arbitration
    // ----------------------------------------------------------------
    assign req      = SRC_EVENT & SRC_ENABLE;
    assign prio_all = {prio_vectors_d[3:0], prio_vectors_c,
                       prio_vectors_b, prio_vectors_a};
    assign cur_code = {LEVEL_MASK_HIGH, LEVEL_MASK_LOW};

    npic_arbiter #(
        .NV       (NV)
    ) u_arb (
        .req      (req),
        .prio     (prio_all),
        .cur_code (cur_code),
        .found    (arb_found),
        .idx      (arb_idx),
        .code     (arb_code)
    );

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    assign reg_idx = AVS_ADDRESS[7:2];
    assign wr_go   = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0];
    assign status  = {(state != ST_IDLE), trap_pend, cur_code, sel_vec};

    always @* begin
        case (reg_idx)
            `NPIC_IDX_PRIO_A: rd_byte = prio_vectors_a;
            `NPIC_IDX_PRIO_B: rd_byte = prio_vectors_b;
            `NPIC_IDX_PRIO_C: rd_byte = prio_vectors_c;
            `NPIC_IDX_PRIO_D: rd_byte = prio_vectors_d;
            `NPIC_IDX_EDGE:   rd_byte = EXT_EDGE_CTRL;
            `NPIC_IDX_STATUS: rd_byte = status;
            default:          rd_byte = 8'h00;
        endcase
    end

    // one wait cycle: request seen, then waitrequest drops for one edge
    always @* begin
        next_waitreq = 1'b1;
        next_rdata   = AVS_READDATA;
        if (AVS_WAITREQUEST && (AVS_READ || AVS_WRITE)) begin
            next_waitreq = 1'b0;
        end
        if (AVS_WAITREQUEST && AVS_READ) begin
            next_rdata = {24'h000000, rd_byte};
        end
    end

    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h00000000;
        end else begin
            AVS_WAITREQUEST <= next_waitreq;
            AVS_READDATA    <= next_rdata;
        end
    end

    // writes land only at the edge that completes the access
    always @* begin
        next_prio_a = prio_vectors_a;
        next_prio_b = prio_vectors_b;
        next_prio_c = prio_vectors_c;
        next_prio_d = prio_vectors_d;
        next_edge   = EXT_EDGE_CTRL;
        if (wr_go) begin
            case (reg_idx)
                `NPIC_IDX_PRIO_A: next_prio_a = AVS_WRITEDATA[7:0];
                `NPIC_IDX_PRIO_B: next_prio_b = AVS_WRITEDATA[7:0];
                `NPIC_IDX_PRIO_C: next_prio_c = AVS_WRITEDATA[7:0];
                // upper half has no vectors behind it and stays ones
                `NPIC_IDX_PRIO_D: next_prio_d = `NPIC_PRIO_D_FIXED |
                                      (AVS_WRITEDATA[7:0] & `NPIC_PRIO_D_WMASK);
                `NPIC_IDX_EDGE:   next_edge   = AVS_WRITEDATA[7:0];
                default: ;
            endcase
        end
    end

    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            prio_vectors_a <= `NPIC_PRIO_RST;
            prio_vectors_b <= `NPIC_PRIO_RST;
            prio_vectors_c <= `NPIC_PRIO_RST;
            prio_vectors_d <= `NPIC_PRIO_RST;
            EXT_EDGE_CTRL  <= `NPIC_EDGE_RST;
        end else begin
            prio_vectors_a <= next_prio_a;
            prio_vectors_b <= next_prio_b;
            prio_vectors_c <= next_prio_c;
            prio_vectors_d <= next_prio_d;
            EXT_EDGE_CTRL  <= next_edge;
        end
    end

    // ----------------------------------------------------------------
    // trap pending: a new trap wins over the clear of the one taken
    // ----------------------------------------------------------------
    assign take_trap = (state == ST_WAIT) & CORE_INSTR_DONE & trap_pend;

    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            trap_pend <= 1'b0;
        end else begin
            trap_pend <= CORE_TRAP | (trap_pend & ~take_trap);
        end
    end

    // ----------------------------------------------------------------
    // entry and return sequencer
    // ----------------------------------------------------------------
    // entry choice at the boundary: the trap first, then the arbiter
    always @* begin
        entry_go   = 1'b0;
        entry_vec  = sel_vec;
        entry_code = sel_code;
        if (trap_pend) begin
            entry_go   = 1'b1;
            entry_vec  = `NPIC_VIDX_TRAP;
            entry_code = `NPIC_LVL3;
        end else if (arb_found && !CORE_RETURN) begin
            entry_go   = 1'b1;
            entry_vec  = arb_idx + `NPIC_VIDX_FIRST;
            entry_code = arb_code;
        end
    end

    // next values first, so the return restore sits in one place
    always @* begin
        next_state      = state;
        next_sel_vec    = sel_vec;
        next_sel_code   = sel_code;
        next_mask       = cur_code;
        next_irq        = IRQ_PENDING;
        next_push       = STK_PUSH;
        next_stk_sel    = STK_SEL;
        next_push_flags = PUSH_FLAGS;
        next_vec_load   = 1'b0;
        next_vec_addr   = VEC_ADDR;
        // a return only lands while no entry is under way
        if (CORE_RETURN && ((state == ST_IDLE) || (state == ST_WAIT))) begin
            next_mask = {CORE_POP_FLAGS[`NPIC_FLAG_HIGH], CORE_POP_FLAGS[`NPIC_FLAG_LOW]};
        end
        case (state)
            ST_IDLE: begin
                if (trap_pend || CORE_TRAP || arb_found) begin
                    next_irq   = 1'b1;
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // decide only at the boundary; a request may have gone
                if (CORE_INSTR_DONE) begin
                    next_irq        = 1'b0;
                    next_push_flags = merge_flags(CORE_FLAGS, cur_code);
                    next_stk_sel    = `NPIC_STK_PC;
                    next_state      = ST_IDLE;
                    if (entry_go) begin
                        next_sel_vec  = entry_vec;
                        next_sel_code = entry_code;
                        next_push     = 1'b1;
                        next_state    = ST_PUSH;
                    end
                end
            end
            ST_PUSH: begin
                if (CORE_STK_ACK) begin
                    if (STK_SEL == `NPIC_STK_FLAGS) begin
                        next_push  = 1'b0;
                        next_mask  = sel_code;
                        next_state = ST_VEC;
                    end else begin
                        next_stk_sel = STK_SEL + 2'h1;
                    end
                end
            end
            ST_VEC: begin
                next_vec_load = 1'b1;
                next_vec_addr = vec_addr(sel_vec);
                next_state    = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // after reset the reset vector is fetched with no stack save
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state           <= ST_VEC;
            sel_vec         <= `NPIC_VIDX_RESET;
            sel_code        <= `NPIC_LVL3;
            LEVEL_MASK_HIGH <= 1'b1;
            LEVEL_MASK_LOW  <= 1'b1;
            IRQ_PENDING     <= 1'b0;
            STK_PUSH        <= 1'b0;
            STK_SEL         <= `NPIC_STK_PC;
            PUSH_FLAGS      <= 8'h00;
            VEC_LOAD        <= 1'b0;
            VEC_ADDR        <= 16'h0000;
        end else begin
            state           <= next_state;
            sel_vec         <= next_sel_vec;
            sel_code        <= next_sel_code;
            LEVEL_MASK_HIGH <= next_mask[1];
            LEVEL_MASK_LOW  <= next_mask[0];
            IRQ_PENDING     <= next_irq;
            STK_PUSH        <= next_push;
            STK_SEL         <= next_stk_sel;
            PUSH_FLAGS      <= next_push_flags;
            VEC_LOAD        <= next_vec_load;
            VEC_ADDR        <= next_vec_addr;
        end
    end

endmodule // npic_top

`default_nettype wire

// ### verif/npic_chk.sv
// port assertions for the nested priority interrupt controller
`timescale 1ns/1ps
`default_nettype none
module npic_chk (
    input wire logic        SYS_CLK,         // clock
    input wire logic        RST_N,           // reset
    input wire logic        AVS_READ,        // bus read
    input wire logic        AVS_WRITE,       // bus write
    input wire logic        AVS_WAITREQUEST, // bus stall
    input wire logic        CORE_INSTR_DONE, // boundary
    input wire logic        CORE_RETURN,     // return
    input wire logic [7:0]  CORE_POP_FLAGS,  // popped flags
    input wire logic        CORE_STK_ACK,    // push ack
    input wire logic        IRQ_PENDING,     // entry wanted
    input wire logic        STK_PUSH,        // push request
    input wire logic [1:0]  STK_SEL,         // push item
    input wire logic [7:0]  PUSH_FLAGS,      // pushed flags
    input wire logic        VEC_LOAD,        // pc load
    input wire logic [15:0] VEC_ADDR,        // vector
    input wire logic        LEVEL_MASK_HIGH, // mask high
    input wire logic        LEVEL_MASK_LOW   // mask low
);
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    wire [1:0] mask;
    assign mask = {LEVEL_MASK_HIGH, LEVEL_MASK_LOW};
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);

    a_wait_once: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("bus wait not one cycle");
    a_push_step: assert property (STK_PUSH && CORE_STK_ACK && STK_SEL != 2'h3 |=> STK_SEL == $past(STK_SEL) + 2'h1)
        else $error("stack item order broken");
    a_push_hold: assert property (STK_PUSH && !CORE_STK_ACK |=> STK_PUSH && $stable(STK_SEL) && $stable(mask))
        else $error("push not held");
    a_entry_start: assert property ($rose(STK_PUSH) |-> STK_SEL == 2'h0 && $past(CORE_INSTR_DONE) && $past(IRQ_PENDING))
        else $error("entry not at boundary");
    a_push_flags: assert property ($rose(STK_PUSH) |-> {PUSH_FLAGS[5], PUSH_FLAGS[3]} == mask)
        else $error("pushed flags lack old mask");
    a_vec_after: assert property ($fell(STK_PUSH) |=> VEC_LOAD ##1 !VEC_LOAD)
        else $error("vector load not after save");
    a_ret_restore: assert property (CORE_RETURN && !IRQ_PENDING && !STK_PUSH && !VEC_LOAD |=>
        mask == {$past(CORE_POP_FLAGS[5]), $past(CORE_POP_FLAGS[3])})
        else $error("return did not restore mask");
    a_trap_mask: assert property (VEC_LOAD && VEC_ADDR == 16'hfffc |-> mask == 2'h3)
        else $error("trap level wrong");
    a_vec_map: assert property (VEC_LOAD |-> VEC_ADDR[15:5] == 11'h7ff && !VEC_ADDR[0])
        else $error("vector outside table");
    a_boot_vec: assert property ($rose(RST_N) |=> VEC_LOAD && VEC_ADDR == 16'hfffe)
        else $error("reset vector missing");
endmodule // npic_chk

bind npic_top npic_chk npic_chk_inst (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .CORE_INSTR_DONE(CORE_INSTR_DONE), .CORE_RETURN(CORE_RETURN),
    .CORE_POP_FLAGS(CORE_POP_FLAGS), .CORE_STK_ACK(CORE_STK_ACK), .IRQ_PENDING(IRQ_PENDING),
    .STK_PUSH(STK_PUSH), .STK_SEL(STK_SEL), .PUSH_FLAGS(PUSH_FLAGS), .VEC_LOAD(VEC_LOAD),
    .VEC_ADDR(VEC_ADDR), .LEVEL_MASK_HIGH(LEVEL_MASK_HIGH), .LEVEL_MASK_LOW(LEVEL_MASK_LOW)
);
`default_nettype wire

// ### verif/npic_core_model.sv
// behavioural core: instruction boundaries and stack acks
`timescale 1ns/1ps
`default_nettype none
module npic_core_model (
    input  wire logic       clk,        // core clock
    input  wire logic       rst_n,      // active low reset
    input  wire logic [1:0] dly,        // idle cycles before each ack
    input  wire logic       stk_push,   // push request
    output var  logic       instr_done, // boundary pulse
    output var  logic       stk_ack     // one item stored
);
    // ----------------------------------------------------------------
    // boundary every fourth cycle, acks after dly
    // ----------------------------------------------------------------
    logic [1:0] ic;
    logic [1:0] wc;
    always @(posedge clk) begin
        if (!rst_n) begin
            ic <= 2'h0;
            wc <= 2'h0;
            instr_done <= 1'b0;
            stk_ack <= 1'b0;
        end else begin
            ic <= ic + 2'h1;
            instr_done <= (ic == 2'h3);
            // ack is a pulse so a held ack never stores two items
            if (stk_push && !stk_ack && wc >= dly) begin
                stk_ack <= 1'b1;
                wc <= 2'h0;
            end else begin
                stk_ack <= 1'b0;
                wc <= stk_push ? wc + 2'h1 : 2'h0;
            end
        end
    end
endmodule // npic_core_model
`default_nettype wire

// ### verif/tb_npic_top.sv
// self-checking bench for the nested priority interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb_npic_top;
    logic        clk;
    logic        rst_n;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [13:0] ev;
    logic [13:0] en;
    logic [7:0]  pop;
    logic [7:0]  flags;
    logic [15:0] vaddr;
    logic [7:0]  edge_ctrl;
    logic [7:0]  pflags;
    logic [3:0]  be;
    logic [1:0]  dly;
    logic        rd, wr, waitreq, done_p, trap, ret, ack, pend, push, vload, mh, ml;
    int          fail_count = 0;
    int          cmp_count = 0;

    npic_top npic_top_inst (
        .SYS_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
        .SRC_EVENT(ev), .SRC_ENABLE(en), .CORE_INSTR_DONE(done_p), .CORE_TRAP(trap), .CORE_RETURN(ret),
        .CORE_POP_FLAGS(pop), .CORE_FLAGS(flags), .CORE_STK_ACK(ack), .IRQ_PENDING(pend), .STK_PUSH(push),
        .STK_SEL(), .PUSH_FLAGS(pflags), .VEC_LOAD(vload), .VEC_ADDR(vaddr), .LEVEL_MASK_HIGH(mh),
        .LEVEL_MASK_LOW(ml), .EXT_EDGE_CTRL(edge_ctrl)
    );
    npic_core_model npic_core_model_inst (
        .clk(clk), .rst_n(rst_n), .dly(dly), .stk_push(push), .instr_done(done_p), .stk_ack(ack)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // read values are the ones sampled at the completing edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        addr <= a;
        wr <= w;
        rd <= ~w;
        wdata <= {24'h0, d};
        @(posedge clk);
        while (waitreq !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) fail_count++;
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_vec(input logic [15:0] va, input logic [1:0] m);
        int n;
        n = 0;
        while (vload !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n == 200) fail_count++;
        chk("vector", vaddr, va);
        chk("mask", {14'h0, mh, ml}, {14'h0, m});
    endtask
    task automatic no_entry(input string name);
        repeat (6) @(posedge clk);
        chk(name, {13'h0, pend, push, vload}, 16'h0000);
    endtask
    task automatic do_ret(input logic [7:0] f);
        pop <= f;
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        repeat (2) @(posedge clk);
        chk("restored mask", {14'h0, mh, ml}, {14'h0, f[5], f[3]});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        logic [7:0] q;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 8'h90 + 8'(i * 4), 8'h00, q);
            chk("prio reset", {8'h0, q}, 16'h00ff);
        end
        bus(1'b1, 8'h9c, 8'h00, q);
        bus(1'b0, 8'h9c, 8'h00, q);
        chk("prio d fixed", {8'h0, q}, 16'h00f0);
        bus(1'b1, 8'h90, 8'h51, q);
        bus(1'b0, 8'h90, 8'h00, q);
        chk("prio a", {8'h0, q}, 16'h0051);
        be <= 4'h0;
        bus(1'b1, 8'h94, 8'h00, q);
        be <= 4'h1;
        bus(1'b0, 8'h94, 8'h00, q);
        chk("lane off", {8'h0, q}, 16'h00ff);
        bus(1'b0, 8'h00, 8'h00, q);
        chk("unmapped", {8'h0, q}, 16'h0000);
        bus(1'b1, 8'ha0, 8'h5a, q);
        chk("edge ctrl", {8'h0, edge_ctrl}, 16'h005a);
        $display("test regs done");
    endtask
    task automatic t_gate;
        ev <= 14'h0001;
        en <= 14'h0001;
        no_entry("level three blocks");
        en <= 14'h0000;
        do_ret(8'h20);
        no_entry("enable off");
        ev <= 14'h0000;
        $display("test gate done");
    endtask
    task automatic t_tie;
        dly <= 2'h2;
        @(posedge clk);
        en <= 14'h3fff;
        ev <= 14'h000c;
        wait_vec(16'hfff6, 2'h1);
        chk("pushed flags", {8'h0, pflags}, 16'h00f7);
        ev <= 14'h0000;
        $display("test tie done");
    endtask
    task automatic t_nest;
        dly <= 2'h0;
        @(posedge clk);
        ev <= 14'h0001;
        no_entry("equal level");
        ev <= 14'h0003;
        wait_vec(16'hfff8, 2'h0);
        ev <= 14'h0000;
        do_ret(8'h08);
        do_ret(8'h28);
        $display("test nest done");
    endtask
    task automatic t_trap;
        logic [7:0] q;
        dly <= 2'h1;
        trap <= 1'b1;
        @(posedge clk);
        trap <= 1'b0;
        wait_vec(16'hfffc, 2'h3);
        bus(1'b0, 8'ha4, 8'h00, q);
        chk("status", {8'h0, q}, 16'h0031);
        $display("test trap done");
    endtask

    initial begin
        rst_n = 1'b0;
        {rd, wr, trap, ret} = 4'h0;
        {addr, wdata, pop} = 48'h0;
        {ev, en} = 28'h0;
        flags = 8'hd7;
        be = 4'h1;
        dly = 2'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        wait_vec(16'hfffe, 2'h3);
        t_regs();
        t_gate();
        t_tie();
        t_nest();
        t_trap();
        print_verdict();
    end
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule // tb_npic_top
`default_nettype wire
